/* hdl/pulse_width_and_event_counter.sv */
// capture, pulse width and event count logic of one 16-bit timer
// assumes configuration ports are static while counting; pins are asynchronous
module pulse_width_and_event_counter
  import pwec_pkg::*;
#(
  parameter int INSTANCE = 0
)
(
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic PRIMARY_CAPTURE_INPUT,
  input wire logic SECONDARY_CAPTURE_INPUT,
  input wire logic [7:0] PRESCALER_EDGE_SELECT_REG,
  input wire logic OP_MODE_BIT_HI,
  input wire logic OP_MODE_BIT_LO,
  input wire logic FIRST_REG_FUNCTION_SEL,
  input wire logic FIRST_REG_CAPTURE_TRIGGER_SEL,
  input wire logic FIRST_WR,
  input wire logic [15:0] FIRST_WDATA,
  input wire logic TIMER_OUTPUT_REQ,
  output logic [15:0] MAIN_UP_COUNTER,
  output logic [15:0] FIRST_CAPTURE_COMPARE_REG,
  output logic [15:0] SECOND_CAPTURE_COMPARE_REG,
  output logic FIRST_MATCH_CAPTURE_IRQ,
  output logic SECOND_CAPTURE_IRQ,
  output logic OVERFLOW_FLAG,
  output logic TIMER_OUTPUT_PIN
);
  logic rst_meta, rst_n;
  logic pri_meta_reg, pri_meta_next, pri_sync_reg, pri_sync_next;
  logic sec_meta_reg, sec_meta_next, sec_sync_reg, sec_sync_next;
  logic [2:0] div_reg, div_next;
  logic [1:0] mode, clk_sel, pri_es, sec_es;
  logic event_mode, tick, sample_en;
  logic pri_rise, pri_fall, pri_hit, sec_hit;
  logic [15:0] cnt_reg, cnt_next, cr0_reg, cr0_next, cr1_reg, cr1_next;
  logic irq0_reg, irq0_next, irq1_reg, irq1_next, ovf_reg, ovf_next;
  logic out_reg, out_next, cap0_pri, counting, match;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  always_comb begin
    pri_meta_next = PRIMARY_CAPTURE_INPUT;
    pri_sync_next = pri_meta_reg;
    sec_meta_next = SECONDARY_CAPTURE_INPUT;
    sec_sync_next = sec_meta_reg;
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pri_meta_reg <= 1'b0;
      pri_sync_reg <= 1'b0;
      sec_meta_reg <= 1'b0;
      sec_sync_reg <= 1'b0;
    end else begin
      pri_meta_reg <= pri_meta_next;
      pri_sync_reg <= pri_sync_next;
      sec_meta_reg <= sec_meta_next;
      sec_sync_reg <= sec_sync_next;
    end
  end

  assign mode = {OP_MODE_BIT_HI, OP_MODE_BIT_LO};
  assign pri_es = PRESCALER_EDGE_SELECT_REG[PRI_ES_LSB +: 2]; // RQ1
  assign sec_es = PRESCALER_EDGE_SELECT_REG[SEC_ES_LSB +: 2]; // RQ4
  assign clk_sel = PRESCALER_EDGE_SELECT_REG[CLK_SEL_LSB +: 2];
  assign event_mode = (clk_sel == CLK_EXT);
  assign counting = (mode != MODE_STOP);

  // prescaler: /2, /4, /8 count clock; event sampling fixed at /4
  always_comb begin
    div_next = div_reg + 3'h1;
    if (!counting) div_next = DIV_RESET;
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) div_reg <= DIV_RESET;
    else div_reg <= div_next;
  end

  always_comb begin
    case (clk_sel)
      CLK_DIV2: tick = counting & div_reg[0];
      CLK_DIV4: tick = counting & (div_reg[1:0] == EVT_DIV_LAST[1:0]);
      CLK_DIV8: tick = counting & (div_reg == DIV8_LAST);
      default: tick = 1'b0;
    endcase
  end

  assign sample_en = event_mode ?
      (counting & (div_reg[1:0] == EVT_DIV_LAST[1:0])) : tick; // RQ12 RQ3

  edge_filter u_pri (
    .clk(CLK),
    .rst_n(rst_n),
    .sample_en(sample_en),
    .din(pri_sync_reg),
    .edge_sel(pri_es),
    .rise(pri_rise),
    .fall(pri_fall),
    .hit(pri_hit)
  );

  edge_filter u_sec (
    .clk(CLK),
    .rst_n(rst_n),
    .sample_en(sample_en),
    .din(sec_sync_reg),
    .edge_sel(sec_es),
    .rise(),
    .fall(),
    .hit(sec_hit)
  );

  // opposite primary edge for two-register capture; none when both edges chosen
  always_comb begin
    case (pri_es)
      ES_RISE: cap0_pri = pri_fall; // RQ5
      ES_FALL: cap0_pri = pri_rise; // RQ5
      default: cap0_pri = 1'b0; // RQ6 RQ8
    endcase
  end

  assign match = (cnt_reg == cr0_reg);

  always_comb begin
    cnt_next = cnt_reg;
    cr0_next = cr0_reg;
    cr1_next = cr1_reg;
    irq0_next = 1'b0;
    irq1_next = 1'b0;
    ovf_next = ovf_reg;
    if (!counting) begin
      cnt_next = CNT_RESET;
    end else if (event_mode) begin
      if (pri_hit) begin
        if (!FIRST_REG_FUNCTION_SEL && match && (mode == MODE_CLEAR_MATCH)) begin
          cnt_next = CNT_RESET; // RQ10 RQ16
        end else begin
          cnt_next = cnt_reg + 16'h0001; // RQ9
        end
      end
    end else if (tick) begin
      if (mode == MODE_CLEAR_MATCH && !FIRST_REG_FUNCTION_SEL && match) begin
        cnt_next = CNT_RESET; // RQ15
      end else begin
        cnt_next = cnt_reg + 16'h0001; // RQ19
        if (cnt_reg == CNT_MAX) ovf_next = 1'b1;
      end
    end
    if (counting && !event_mode && !FIRST_REG_FUNCTION_SEL && mode == MODE_CLEAR_MATCH &&
        tick && match) begin
      irq0_next = 1'b1; // RQ15
    end
    if (counting && event_mode && !FIRST_REG_FUNCTION_SEL && mode == MODE_CLEAR_MATCH &&
        pri_hit && match) begin
      irq0_next = 1'b1; // RQ10
    end
    if (counting && !event_mode) begin
      if (pri_hit) begin
        cr1_next = cnt_reg; // RQ2 RQ7
        irq1_next = 1'b1; // RQ2
        if (mode == MODE_RESTART_EDGE) cnt_next = CNT_RESET; // RQ7
      end
      if (FIRST_REG_FUNCTION_SEL) begin
        if (FIRST_REG_CAPTURE_TRIGGER_SEL ? cap0_pri : sec_hit) begin
          cr0_next = cnt_reg; // RQ4 RQ5
          irq0_next = 1'b1; // RQ4
        end
      end
    end
    if (FIRST_WR && !FIRST_REG_FUNCTION_SEL) cr0_next = FIRST_WDATA;
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= CNT_RESET;
      cr0_reg <= CNT_RESET;
      cr1_reg <= CNT_RESET;
      irq0_reg <= 1'b0;
      irq1_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      cr0_reg <= cr0_next;
      cr1_reg <= cr1_next;
      irq0_reg <= irq0_next;
      irq1_reg <= irq1_next;
      ovf_reg <= ovf_next;
    end
  end

  // output pin forced low on the first instances while event counting
  always_comb begin
    out_next = TIMER_OUTPUT_REQ;
    if (event_mode && counting && INSTANCE < NUM_NO_OUT_INST) out_next = 1'b0; // RQ13
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      out_reg <= 1'b0;
    end else begin
      out_reg <= out_next;
    end
  end

  assign MAIN_UP_COUNTER = cnt_reg;
  assign FIRST_CAPTURE_COMPARE_REG = cr0_reg;
  assign SECOND_CAPTURE_COMPARE_REG = cr1_reg;
  assign FIRST_MATCH_CAPTURE_IRQ = irq0_reg;
  assign SECOND_CAPTURE_IRQ = irq1_reg;
  assign OVERFLOW_FLAG = ovf_reg;
  assign TIMER_OUTPUT_PIN = out_reg;
endmodule

/* hdl/pwec_pkg.sv */
// constants for the pulse width and event counter block
// assumes one 200 MHz clock; configuration bits arrive as plain ports from software logic
// Summary of operation
// RQ1 - primary capture edge chosen by prescaler bits 4 and 5
// RQ2 - free-running: primary edge copies counter into second register, raises second irq
// RQ3 - inputs sampled at count clock; edge accepted after two matching samples
// RQ4 - dual mode: bits 6,7 pick secondary edge; copies into first register, first irq
// RQ5 - two-register mode: opposite primary edge copies counter into first register
// RQ6 - two-register mode with both edges: first register does no capture
// RQ7 - restart mode: capture into second register, then clear counter and continue
// RQ8 - restart mode with both edges: no capture into first register
// RQ9 - event mode: counter increments once per valid primary edge
// RQ10 - event mode: counter equal to first register clears to zero, first irq
// RQ11 - software loads a nonzero first compare value for event counting
// RQ12 - event mode samples input at system clock over four, two samples needed
// RQ13 - timer output unavailable on first four instances while event counting
// RQ14 - software leaves capture/compare registers alone while counting
// RQ15 - mode bits 1,1 clear and restart counter on first register match
// RQ16 - function select bit 0 clear makes first register a compare register
// RQ17 - software configures pins, control, prescaler, irq enable, then mode to start
// RQ18 - edge field: 00 falling, 01 rising, 11 both, 10 prohibited
// RQ19 - free-running counter wraps from maximum to zero, capture never clears it
package pwec_pkg;
  localparam int CNT_W = 16;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam int PRI_ES_LSB = 4;
  localparam int SEC_ES_LSB = 6;
  localparam int CLK_SEL_LSB = 0;
  localparam logic [1:0] ES_FALL = 2'h0;
  localparam logic [1:0] ES_RISE = 2'h1;
  localparam logic [1:0] ES_BAD = 2'h2;
  localparam logic [1:0] ES_BOTH = 2'h3;
  localparam logic [1:0] MODE_STOP = 2'h0;
  localparam logic [1:0] MODE_FREE = 2'h1;
  localparam logic [1:0] MODE_RESTART_EDGE = 2'h2;
  localparam logic [1:0] MODE_CLEAR_MATCH = 2'h3;
  localparam logic [1:0] CLK_DIV2 = 2'h0;
  localparam logic [1:0] CLK_DIV4 = 2'h1;
  localparam logic [1:0] CLK_DIV8 = 2'h2;
  localparam logic [1:0] CLK_EXT = 2'h3;
  localparam logic [2:0] DIV_RESET = 3'h0;
  localparam logic [2:0] EVT_DIV_LAST = 3'h3;
  localparam logic [2:0] DIV8_LAST = 3'h7;
  localparam int NUM_NO_OUT_INST = 4;
endpackage

/* hdl/edge_filter.sv */
// two-sample noise filter and edge detector for one capture input
// assumes the input is already synchronised to clk; sample_en is a one-cycle pulse
module edge_filter
  import pwec_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sample_en,
  input wire logic din,
  input wire logic [1:0] edge_sel,
  output logic rise,
  output logic fall,
  output logic hit
);
  logic s_reg, s_next, lvl_reg, lvl_next;

  always_comb begin
    s_next = s_reg;
    lvl_next = lvl_reg;
    if (sample_en) begin
      s_next = din;
      if (din == s_reg) lvl_next = s_reg; // RQ3
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= 1'b0;
      lvl_reg <= 1'b0;
    end else begin
      s_reg <= s_next;
      lvl_reg <= lvl_next;
    end
  end

  assign rise = lvl_next & ~lvl_reg;
  assign fall = ~lvl_next & lvl_reg;

  always_comb begin
    case (edge_sel) // RQ18
      ES_FALL: hit = fall;
      ES_RISE: hit = rise;
      ES_BOTH: hit = rise | fall;
      default: hit = 1'b0;
    endcase
  end
endmodule

/* dv/pwec_props.sv */
// port assertions for the pulse width and event counter
// bound to the top module, sees its ports only
module pwec_props
  import pwec_pkg::*;
#(
  parameter int INSTANCE = 0
)
(
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [7:0] PRESCALER_EDGE_SELECT_REG,
  input wire logic OP_MODE_BIT_HI,
  input wire logic OP_MODE_BIT_LO,
  input wire logic FIRST_REG_FUNCTION_SEL,
  input wire logic FIRST_REG_CAPTURE_TRIGGER_SEL,
  input wire logic [15:0] MAIN_UP_COUNTER,
  input wire logic [15:0] FIRST_CAPTURE_COMPARE_REG,
  input wire logic [15:0] SECOND_CAPTURE_COMPARE_REG,
  input wire logic FIRST_MATCH_CAPTURE_IRQ,
  input wire logic SECOND_CAPTURE_IRQ,
  input wire logic TIMER_OUTPUT_PIN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  logic [1:0] mode;
  logic [1:0] pes;
  assign mode = {OP_MODE_BIT_HI, OP_MODE_BIT_LO};
  assign pes = PRESCALER_EDGE_SELECT_REG[5:4];
  sequence evt_s;
    PRESCALER_EDGE_SELECT_REG[1:0] == CLK_EXT && mode == MODE_CLEAR_MATCH;
  endsequence
  sequence cap1_s;
    FIRST_MATCH_CAPTURE_IRQ && FIRST_REG_FUNCTION_SEL;
  endsequence
  a_second_irq_pulse: assert property (SECOND_CAPTURE_IRQ |=> !SECOND_CAPTURE_IRQ)
    else $error("second irq longer than one cycle");
  a_second_cap_value: assert property (SECOND_CAPTURE_IRQ && mode == MODE_FREE |->
    SECOND_CAPTURE_COMPARE_REG == $past(MAIN_UP_COUNTER))
    else $error("second capture value wrong");
  a_first_cap_value: assert property (cap1_s |->
    FIRST_CAPTURE_COMPARE_REG == $past(MAIN_UP_COUNTER))
    else $error("first capture value wrong");
  a_both_no_first: assert property ((FIRST_REG_FUNCTION_SEL &&
    FIRST_REG_CAPTURE_TRIGGER_SEL && pes == ES_BOTH)[*3] |-> !FIRST_MATCH_CAPTURE_IRQ)
    else $error("first capture with both edges");
  a_restart_clear: assert property (SECOND_CAPTURE_IRQ && mode == MODE_RESTART_EDGE |->
    MAIN_UP_COUNTER == CNT_RESET) else $error("restart did not clear counter");
  a_event_clear: assert property (evt_s and FIRST_MATCH_CAPTURE_IRQ |->
    MAIN_UP_COUNTER == CNT_RESET && $past(MAIN_UP_COUNTER) == FIRST_CAPTURE_COMPARE_REG)
    else $error("event match clear wrong");
  a_out_blocked: assert property (evt_s [*2] ##0 INSTANCE < NUM_NO_OUT_INST |->
    !TIMER_OUTPUT_PIN) else $error("timer output active while event counting");
  a_edge_bad: assert property ((pes == ES_BAD && mode != MODE_STOP)[*8] |->
    !SECOND_CAPTURE_IRQ) else $error("capture on prohibited edge setting");
endmodule

bind pulse_width_and_event_counter pwec_props #(.INSTANCE(INSTANCE)) u_pwec_props (
  .CLK(CLK), .ARST_N(ARST_N), .PRESCALER_EDGE_SELECT_REG(PRESCALER_EDGE_SELECT_REG),
  .OP_MODE_BIT_HI(OP_MODE_BIT_HI), .OP_MODE_BIT_LO(OP_MODE_BIT_LO),
  .FIRST_REG_FUNCTION_SEL(FIRST_REG_FUNCTION_SEL),
  .FIRST_REG_CAPTURE_TRIGGER_SEL(FIRST_REG_CAPTURE_TRIGGER_SEL),
  .MAIN_UP_COUNTER(MAIN_UP_COUNTER), .FIRST_CAPTURE_COMPARE_REG(FIRST_CAPTURE_COMPARE_REG),
  .SECOND_CAPTURE_COMPARE_REG(SECOND_CAPTURE_COMPARE_REG),
  .FIRST_MATCH_CAPTURE_IRQ(FIRST_MATCH_CAPTURE_IRQ), .SECOND_CAPTURE_IRQ(SECOND_CAPTURE_IRQ),
  .TIMER_OUTPUT_PIN(TIMER_OUTPUT_PIN));

/* dv/pin_source.sv */
// external pulse source on one capture pin
// called 1 ns after a rising edge, level changes then
module pin_source (
  input wire logic clk,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pin = 1'b0;
  task hold(input logic v, input int n);
    pin = v;
    repeat (n) @(posedge clk);
    #1;
  endtask
endmodule

/* dv/pulse_width_and_event_counter_tb.sv */
// self-checking bench for the pulse width and event counter
// one 200 MHz clock; two pin sources drive the capture inputs
module pulse_width_and_event_counter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 0, ARST_N = 0, hi = 0, lo = 0, fs = 0, ts = 0, wr = 0, req = 0;
  logic pri, sec, i1, i2, req_pin, ovf;
  logic [7:0] psel = 0;
  logic [15:0] wd = 0, cnt, r1, r2;
  logic [15:0] q1[$], q2[$];
  int fails = 0, checks_done = 0, d, e, k, p, m, cmp, irqs;
  always #2.5 CLK = ~CLK;
  pin_source u_pri (.clk(CLK), .pin(pri));
  pin_source u_sec (.clk(CLK), .pin(sec));
  pulse_width_and_event_counter u_pulse_width_and_event_counter (.CLK(CLK), .ARST_N(ARST_N),
    .PRIMARY_CAPTURE_INPUT(pri), .SECONDARY_CAPTURE_INPUT(sec),
    .PRESCALER_EDGE_SELECT_REG(psel), .OP_MODE_BIT_HI(hi), .OP_MODE_BIT_LO(lo),
    .FIRST_REG_FUNCTION_SEL(fs), .FIRST_REG_CAPTURE_TRIGGER_SEL(ts), .FIRST_WR(wr),
    .FIRST_WDATA(wd), .TIMER_OUTPUT_REQ(req), .MAIN_UP_COUNTER(cnt),
    .FIRST_CAPTURE_COMPARE_REG(r1), .SECOND_CAPTURE_COMPARE_REG(r2),
    .FIRST_MATCH_CAPTURE_IRQ(i1), .SECOND_CAPTURE_IRQ(i2), .OVERFLOW_FLAG(ovf),
    .TIMER_OUTPUT_PIN(req_pin));
  always @(posedge CLK) begin
    if (i1 === 1'b1) q1.push_back(r1);
    if (i2 === 1'b1) q2.push_back(r2);
  end
  task chk(input string nm, input logic [15:0] x, g);
    checks_done++;
    if (g !== x) begin
      fails++;
      $display("unexpected %s exp %h got %h", nm, x, g);
    end
  endtask
  task final_report;
    $display("checks %0d failures %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task cfg(input logic [7:0] s, input logic [1:0] md, input logic f, t, input logic [15:0] c);
    {hi, lo} = 2'b00;
    repeat (4) @(posedge CLK);
    #1;
    psel = s;
    fs = f;
    ts = t;
    wd = c;
    wr = 1'b1;
    @(posedge CLK);
    #1;
    wr = 1'b0;
    {hi, lo} = md;
    q1.delete();
    q2.delete();
  endtask
  task pulses(input int s, n, h, l);
    repeat (n) begin
      if (s != 0) begin
        u_sec.hold(1'b1, h);
        u_sec.hold(1'b0, l);
      end else begin
        u_pri.hold(1'b1, h);
        u_pri.hold(1'b0, l);
      end
    end
    repeat (60) @(posedge CLK);
    #1;
  endtask
  initial begin
    repeat (60000) @(posedge CLK);
    fails++;
    final_report;
  end
  initial begin
    void'($urandom(37320));
    repeat (2) @(posedge CLK);
    #1;
    ARST_N = 1'b1;
    repeat (3) @(posedge CLK);
    #1;
    for (d = 0; d < 3; d++) begin
      for (e = 0; e < 4; e++) begin
        k = 4 + $urandom % 8;
        p = (2 << d) * k * 2;
        cfg({e[1:0], e[1:0], 2'b00, d[1:0]}, 2'h1, 1'b0, 1'b0, 16'h0000);
        pulses(0, 3, p / 2, p / 2);
        chk("captures", 16'((e == 2) ? 0 : (e == 3) ? 6 : 3), 16'(q2.size()));
        for (int i = 1; i < q2.size(); i++)
          chk("width", 16'(p / (2 << d) / ((e == 3) ? 2 : 1)), q2[i] - q2[i-1]);
      end
    end
    cfg(8'h12, 2'h1, 1'b0, 1'b0, 16'h0000);
    pulses(0, 3, 3, 37);
    chk("noise captures", 16'h0000, 16'(q2.size()));
    k = 2 * (4 + $urandom % 8);
    cfg(8'h10, 2'h1, 1'b1, 1'b1, 16'h0000);
    pulses(0, 3, k, 20);
    chk("first captures", 16'h0003, 16'(q1.size()));
    for (int i = 0; i < q1.size(); i++) chk("high time", 16'(k / 2), q1[i] - q2[i]);
    cfg(8'h30, 2'h1, 1'b1, 1'b1, 16'h0000);
    pulses(0, 3, k, 20);
    chk("both first", 16'h0000, 16'(q1.size()));
    cfg(8'h40, 2'h1, 1'b1, 1'b0, 16'h0000);
    pulses(1, 3, k, k);
    chk("secondary captures", 16'h0003, 16'(q1.size()));
    chk("secondary period", 16'(k), q1[2] - q1[1]);
    cfg(8'h10, 2'h2, 1'b0, 1'b0, 16'h0000);
    pulses(0, 4, k, 20);
    chk("restart captures", 16'h0004, 16'(q2.size()));
    for (int i = 1; i < 4; i++) chk("restart width", 16'((k + 20) / 2 - 1), q2[i]);
    cfg(8'h30, 2'h2, 1'b1, 1'b1, 16'h0000);
    pulses(0, 3, k, 20);
    chk("restart both first", 16'h0000, 16'(q1.size()));
    m = 3 + $urandom % 8;
    cfg(8'h00, 2'h3, 1'b0, 1'b0, 16'(m));
    repeat (6 * (m + 1) + 1) @(posedge CLK);
    #1;
    chk("match restarts", 16'h0003, 16'(q1.size()));
    chk("match count", 16'h0000, cnt);
    req = 1'b1;
    @(posedge CLK);
    #1;
    chk("output pin", 16'h0001, 16'(req_pin));
    cmp = 2 + $urandom % 4;
    m = 0;
    irqs = 0;
    cfg(8'h13, 2'h3, 1'b0, 1'b0, 16'(cmp));
    for (int i = 0; i < 12; i++) begin
      u_pri.hold(1'b1, 8);
      u_pri.hold(1'b0, 12);
      u_pri.hold(1'b1, 2);
      u_pri.hold(1'b0, 10);
      irqs += (m == cmp) ? 1 : 0;
      m = (m == cmp) ? 0 : m + 1;
      chk("event count", 16'(m), cnt);
    end
    chk("match irqs", 16'(irqs), 16'(q1.size()));
    chk("blocked pin", 16'h0000, 16'(req_pin));
    chk("overflow", 16'h0000, 16'(ovf));
    final_report;
  end
endmodule
